// *** hw/rom_loader_pkg.sv ***
package rom_loader_pkg;

  // ----------------------------------------------------------------------
  // clock and serial timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  // slow enough for a slow part's data-out delay to settle
  localparam int ROM_SK_HALF_NS = 500;
  localparam int ROM_SK_HALF_CYC =
    (ROM_SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = 3;

  // ----------------------------------------------------------------------
  // serial rom word access
  // ----------------------------------------------------------------------
  localparam int ROM_ADDR_BITS = 6;
  localparam int ROM_WORD_BITS = 16;
  localparam int ROM_OPC_BITS = 3;
  localparam int ROM_CMD_BITS = ROM_OPC_BITS + ROM_ADDR_BITS;
  localparam int ROM_RISE_TOTAL = ROM_CMD_BITS + ROM_WORD_BITS;
  localparam logic [2:0] ROM_READ_OPC = 3'h6;

  localparam logic [5:0] WORD_FIRST = 6'h00;
  localparam logic [5:0] WORD_MAC_LOW = 6'h01;
  localparam logic [5:0] WORD_MAC_MID = 6'h02;
  localparam logic [5:0] WORD_MAC_HIGH = 6'h03;
  localparam logic [5:0] WORD_CONFIG = 6'h06;
  localparam logic [5:0] WORD_LAST = 6'h06;
  localparam int CFG_BUS_WIDTH_BIT = 0;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CHIP_CONFIG = 8'h08;
  localparam logic [7:0] REG_STATION_ADDR_LOW = 8'h10;
  localparam logic [7:0] REG_STATION_ADDR_MID = 8'h12;
  localparam logic [7:0] REG_STATION_ADDR_HIGH = 8'h14;
  localparam logic [7:0] REG_SERIAL_ROM_CONTROL = 8'h22;

  localparam logic [15:0] SERIAL_ROM_CONTROL_RST = 16'h0000;
  localparam logic [15:0] STATION_ADDR_RST = 16'h0000;

  localparam int CCR_ROM_PRESENT_BIT = 9;
  localparam int CCR_BUS16_BIT = 7;
  localparam int CCR_BUS8_BIT = 6;
  localparam int CCR_BUS32_BIT = 5;

  localparam int CTL_DO_BIT = 0;
  localparam int CTL_CS_BIT = 1;
  localparam int CTL_SK_BIT = 2;
  localparam int CTL_DI_BIT = 3;
  localparam int CTL_SW_EN_BIT = 4;
  localparam logic [15:0] CTL_WR_MASK = 16'h001e;

endpackage : rom_loader_pkg

// *** hw/rom_word_reader.sv ***
`timescale 1ns/1ps
`default_nettype none

module rom_word_reader
  import rom_loader_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic [5:0] i_addr,
  input wire logic i_rom_do_sync,
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_data,
  output logic o_cs,
  output logic o_sk,
  output logic o_di
);

  typedef enum logic [1:0] {RD_IDLE, RD_SHIFT, RD_TAIL} rd_state_e;

  rd_state_e state_ff, nxt_state;
  logic [5:0] half_ff, nxt_half;
  logic [4:0] rise_ff, nxt_rise;
  logic [8:0] cmd_ff, nxt_cmd;
  logic [15:0] data_ff, nxt_data;
  logic sk_ff, nxt_sk;
  logic done_ff, nxt_done;

  localparam logic [5:0] HALF_LAST = 6'(ROM_SK_HALF_CYC - 1);
  localparam logic [4:0] RISE_END = 5'(ROM_RISE_TOTAL);
  localparam logic [4:0] RISE_D15 = 5'(ROM_CMD_BITS + 1);

  // --------------------------------------------------------------------
  // one read: start bit, opcode, address msb first, then 16 data bits
  // --------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_half = half_ff;
    nxt_rise = rise_ff;
    nxt_cmd = cmd_ff;
    nxt_data = data_ff;
    nxt_sk = sk_ff;
    nxt_done = 1'b0;
    unique case (state_ff)
      RD_IDLE: begin
        if (i_start) begin
          nxt_state = RD_SHIFT;
          nxt_cmd = {ROM_READ_OPC, i_addr};
          nxt_half = '0;
          nxt_rise = '0;
          nxt_sk = 1'b0;
        end
      end
      RD_SHIFT: begin
        nxt_half = half_ff + 6'h01;
        if (half_ff == HALF_LAST) begin
          nxt_half = '0;
          if (sk_ff) begin
            nxt_sk = 1'b0;
            nxt_cmd = {cmd_ff[7:0], 1'b0};
          end else begin
            // sampled at end of low phase: data has had a full period
            if (rise_ff >= RISE_D15) begin
              nxt_data = {data_ff[14:0], i_rom_do_sync};
            end
            if (rise_ff == RISE_END) begin
              nxt_state = RD_TAIL;
            end else begin
              nxt_sk = 1'b1;
              nxt_rise = rise_ff + 5'h01;
            end
          end
        end
      end
      RD_TAIL: begin
        nxt_half = half_ff + 6'h01;
        if (half_ff == HALF_LAST) begin
          nxt_state = RD_IDLE;
          nxt_done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= RD_IDLE;
      half_ff <= '0;
      rise_ff <= '0;
      cmd_ff <= '0;
      data_ff <= '0;
      sk_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      half_ff <= nxt_half;
      rise_ff <= nxt_rise;
      cmd_ff <= nxt_cmd;
      data_ff <= nxt_data;
      sk_ff <= nxt_sk;
      done_ff <= nxt_done;
    end
  end

  assign o_busy = (state_ff != RD_IDLE);
  assign o_done = done_ff;
  assign o_data = data_ff;
  assign o_cs = (state_ff == RD_SHIFT);
  assign o_sk = sk_ff;
  assign o_di = (state_ff == RD_SHIFT) & cmd_ff[8];

endmodule : rom_word_reader

`default_nettype wire

// *** hw/serial_rom_config_loader.sv ***
// Behaviour
// - strap high: read words 0 to 6 after reset
// - strap low or floating: skip automatic load
// - 16-bit-word microwire rom, one word per access
// - loaded values land in host registers
// - software drives rom through control register 0x22
// - mac bytes from words 1-3, word 0 ignored
// - words 4, 5 and 7 upward unused
// - config word bit 0: 1=16-bit, 0=8-bit
// - bus width shown in chip config bits 7/6
// - 32-bit variant ignores bus width bit
// - chip config register at 0x08 read-only
`timescale 1ns/1ps
`default_nettype none

module serial_rom_config_loader
  import rom_loader_pkg::*;
#(
  parameter bit BUS32_VARIANT = 1'b0,
  parameter bit DEFAULT_BUS16 = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_rom_present_strap,
  input wire logic i_rom_do,
  output logic o_rom_cs,
  output logic o_rom_sk,
  output logic o_rom_di,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_bus16_sel,
  output logic o_load_done
);

  typedef enum logic [1:0] {LD_SETTLE, LD_ISSUE, LD_WAIT, LD_DONE} ld_state_e;

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic strap_meta_ff, strap_sync_ff;
  logic do_meta_ff, do_sync_ff;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_meta_ff <= 1'b0;
      strap_sync_ff <= 1'b0;
      do_meta_ff <= 1'b0;
      do_sync_ff <= 1'b0;
    end else begin
      strap_meta_ff <= i_rom_present_strap;
      strap_sync_ff <= strap_meta_ff;
      do_meta_ff <= i_rom_do;
      do_sync_ff <= do_meta_ff;
    end
  end

  // --------------------------------------------------------------------
  // word reader
  // --------------------------------------------------------------------
  logic rd_busy, rd_done, rd_cs, rd_sk, rd_di;
  logic [15:0] rd_data;
  logic start_ff, nxt_start;
  logic [5:0] word_ff, nxt_word;

  rom_word_reader u_reader (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_start(start_ff),
    .i_addr(word_ff),
    .i_rom_do_sync(do_sync_ff),
    .o_busy(rd_busy),
    .o_done(rd_done),
    .o_data(rd_data),
    .o_cs(rd_cs),
    .o_sk(rd_sk),
    .o_di(rd_di)
  );

  // --------------------------------------------------------------------
  // automatic load sequencer
  // --------------------------------------------------------------------
  ld_state_e state_ff, nxt_state;
  logic [1:0] settle_ff, nxt_settle;
  logic present_ff, nxt_present;
  logic [15:0] mac_low_ff, nxt_mac_low;
  logic [15:0] mac_mid_ff, nxt_mac_mid;
  logic [15:0] mac_high_ff, nxt_mac_high;
  logic bus16_ff, nxt_bus16;
  logic [15:0] ctl_ff, nxt_ctl;
  logic loaded;
  logic wr_hit_ctl;

  localparam logic [1:0] SETTLE_LAST = 2'(SETTLE_CYC - 1);

  assign loaded = (state_ff == LD_DONE);
  assign wr_hit_ctl = i_reg_wr && (i_reg_addr == REG_SERIAL_ROM_CONTROL);

  always_comb begin
    nxt_state = state_ff;
    nxt_settle = settle_ff;
    nxt_present = present_ff;
    nxt_start = 1'b0;
    nxt_word = word_ff;
    nxt_mac_low = mac_low_ff;
    nxt_mac_mid = mac_mid_ff;
    nxt_mac_high = mac_high_ff;
    nxt_bus16 = bus16_ff;
    nxt_ctl = ctl_ff;
    unique case (state_ff)
      LD_SETTLE: begin
        // strap is caught once the synchroniser has refilled after release
        nxt_settle = settle_ff + 2'h1;
        if (settle_ff == SETTLE_LAST) begin
          nxt_present = strap_sync_ff;
          if (strap_sync_ff) begin
            nxt_state = LD_ISSUE;
            nxt_word = WORD_FIRST;
          end else begin
            nxt_state = LD_DONE;
          end
        end
      end
      LD_ISSUE: begin
        if (!rd_busy) begin
          nxt_start = 1'b1;
          nxt_state = LD_WAIT;
        end
      end
      LD_WAIT: begin
        if (rd_done) begin
          // word 0, 4 and 5 are read but dropped
          unique case (word_ff)
            WORD_MAC_LOW: nxt_mac_low = rd_data;
            WORD_MAC_MID: nxt_mac_mid = rd_data;
            WORD_MAC_HIGH: nxt_mac_high = rd_data;
            WORD_CONFIG: nxt_bus16 = rd_data[CFG_BUS_WIDTH_BIT];
            default: ;
          endcase
          if (word_ff == WORD_LAST) begin
            nxt_state = LD_DONE;
          end else begin
            nxt_word = word_ff + 6'h01;
            nxt_state = LD_ISSUE;
          end
        end
      end
      LD_DONE: begin
        if (i_reg_wr) begin
          unique case (i_reg_addr)
            REG_STATION_ADDR_LOW: nxt_mac_low = i_reg_wdata;
            REG_STATION_ADDR_MID: nxt_mac_mid = i_reg_wdata;
            REG_STATION_ADDR_HIGH: nxt_mac_high = i_reg_wdata;
            default: ;
          endcase
        end
      end
    endcase
    if (wr_hit_ctl) begin
      nxt_ctl = i_reg_wdata & CTL_WR_MASK;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= LD_SETTLE;
      settle_ff <= '0;
      present_ff <= 1'b0;
      start_ff <= 1'b0;
      word_ff <= WORD_FIRST;
      mac_low_ff <= STATION_ADDR_RST;
      mac_mid_ff <= STATION_ADDR_RST;
      mac_high_ff <= STATION_ADDR_RST;
      bus16_ff <= DEFAULT_BUS16;
      ctl_ff <= SERIAL_ROM_CONTROL_RST;
    end else begin
      state_ff <= nxt_state;
      settle_ff <= nxt_settle;
      present_ff <= nxt_present;
      start_ff <= nxt_start;
      word_ff <= nxt_word;
      mac_low_ff <= nxt_mac_low;
      mac_mid_ff <= nxt_mac_mid;
      mac_high_ff <= nxt_mac_high;
      bus16_ff <= nxt_bus16;
      ctl_ff <= nxt_ctl;
    end
  end

  // --------------------------------------------------------------------
  // host view and pins
  // --------------------------------------------------------------------
  logic [15:0] rdata_ff, nxt_rdata;
  logic [15:0] ccr_val;
  logic cs_pin_ff, nxt_cs_pin;
  logic sk_pin_ff, nxt_sk_pin;
  logic di_pin_ff, nxt_di_pin;
  logic bus16_out_ff, nxt_bus16_out;
  logic done_out_ff, nxt_done_out;
  logic sw_mode;
  logic shown;

  // reads follow o_load_done, not the sequencer state, so the host never
  // sees a loaded value in the cycle before the done pin rises
  assign shown = done_out_ff;

  // software owns the pins only once the automatic load is finished
  assign sw_mode = loaded && ctl_ff[CTL_SW_EN_BIT];

  always_comb begin
    ccr_val = '0;
    ccr_val[CCR_ROM_PRESENT_BIT] = present_ff;
    if (BUS32_VARIANT) begin
      ccr_val[CCR_BUS32_BIT] = 1'b1;
    end else begin
      ccr_val[CCR_BUS16_BIT] = bus16_ff;
      ccr_val[CCR_BUS8_BIT] = !bus16_ff;
    end
    nxt_rdata = rdata_ff;
    if (i_reg_rd) begin
      nxt_rdata = '0;
      unique case (i_reg_addr)
        REG_CHIP_CONFIG: nxt_rdata = shown ? ccr_val : '0;
        REG_STATION_ADDR_LOW: nxt_rdata = shown ? mac_low_ff : '0;
        REG_STATION_ADDR_MID: nxt_rdata = shown ? mac_mid_ff : '0;
        REG_STATION_ADDR_HIGH: nxt_rdata = shown ? mac_high_ff : '0;
        REG_SERIAL_ROM_CONTROL: begin
          nxt_rdata = ctl_ff;
          nxt_rdata[CTL_DO_BIT] = do_sync_ff;
        end
        default: nxt_rdata = '0;
      endcase
    end
    nxt_cs_pin = sw_mode ? ctl_ff[CTL_CS_BIT] : rd_cs;
    nxt_sk_pin = sw_mode ? ctl_ff[CTL_SK_BIT] : rd_sk;
    nxt_di_pin = sw_mode ? ctl_ff[CTL_DI_BIT] : rd_di;
    nxt_bus16_out = BUS32_VARIANT ? 1'b0 : bus16_ff;
    nxt_done_out = loaded;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= '0;
      cs_pin_ff <= 1'b0;
      sk_pin_ff <= 1'b0;
      di_pin_ff <= 1'b0;
      bus16_out_ff <= 1'b0;
      done_out_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      cs_pin_ff <= nxt_cs_pin;
      sk_pin_ff <= nxt_sk_pin;
      di_pin_ff <= nxt_di_pin;
      bus16_out_ff <= nxt_bus16_out;
      done_out_ff <= nxt_done_out;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_rom_cs = cs_pin_ff;
  assign o_rom_sk = sk_pin_ff;
  assign o_rom_di = di_pin_ff;
  assign o_bus16_sel = bus16_out_ff;
  assign o_load_done = done_out_ff;

endmodule : serial_rom_config_loader

`default_nettype wire

// *** tb/loader_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module loader_checker
  import rom_loader_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_rom_present_strap,
  input wire logic o_rom_cs,
  input wire logic o_rom_sk,
  input wire logic o_rom_di,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_bus16_sel,
  input wire logic o_load_done
);
  // ----------------------------------------------------------------------
  // edges since reset release, saturating
  // ----------------------------------------------------------------------
  logic [3:0] cyc_ff;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cyc_ff <= 4'h0;
    end else if (cyc_ff != 4'hf) begin
      cyc_ff <= cyc_ff + 4'h1;
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  skip_load_a: assert property (cyc_ff == 4'h7 && !i_rom_present_strap
    |-> o_load_done && !o_rom_cs) else $error("load not skipped");
  load_start_a: assert property (cyc_ff == 4'h9 && i_rom_present_strap
    |-> o_rom_cs && !o_load_done) else $error("load not started");
  done_hold_a: assert property (o_load_done |=> o_load_done)
    else $error("load done dropped");
  sk_frame_a: assert property (o_rom_sk && !o_load_done |-> o_rom_cs)
    else $error("serial clock outside frame");
  sk_half_a: assert property ($rose(o_rom_sk) && !o_load_done
    |-> ##12 o_rom_sk ##1 !o_rom_sk) else $error("serial clock half period");
  first_rise_a: assert property ($rose(o_rom_cs) && !o_load_done
    |-> !o_rom_sk [*8] ##5 !o_rom_sk ##1 o_rom_sk)
    else $error("first serial clock edge late or early");
  start_bit_a: assert property ($rose(o_rom_cs) |-> o_rom_di)
    else $error("start bit missing");
  di_hold_a: assert property (o_rom_sk && !o_load_done
    |-> $stable(o_rom_di)) else $error("data in moved while clock high");
  cs_gap_a: assert property ($fell(o_rom_cs) && !o_load_done
    |-> !o_rom_cs [*8]) else $error("chip select gap too short");
  hidden_a: assert property (i_reg_rd && !o_load_done
    && i_reg_addr != REG_SERIAL_ROM_CONTROL |=> o_reg_rdata == 16'h0000)
    else $error("register visible before load done");
  width_hold_a: assert property (o_load_done |=> $stable(o_bus16_sel))
    else $error("bus width changed after load");

  cover property (o_load_done && o_bus16_sel);
  cover property (o_load_done && !o_bus16_sel);
  cover property ($rose(o_rom_cs) && o_load_done);
endmodule : loader_checker

bind serial_rom_config_loader loader_checker i_chk (.i_ref_clk, .i_resetn,
  .i_rom_present_strap, .o_rom_cs, .o_rom_sk, .o_rom_di, .i_reg_addr,
  .i_reg_rd, .o_reg_rdata, .o_bus16_sel, .o_load_done);

`default_nettype wire

// *** tb/rom_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module rom_model (
  input wire logic i_cs,
  input wire logic i_sk,
  input wire logic i_di,
  output logic o_do
);
  // 64 words of 16 bits; bench loads contents and reads the logs
  logic [15:0] mem [64];
  logic [5:0] addr_log [8];
  logic [2:0] opc_log [8];
  logic [8:0] cmd;
  int reads;
  int rises;

  initial begin
    o_do = 1'b0;
    reads = 0;
    rises = 0;
    cmd = 9'h000;
  end

  // output delay stands for a slow part's clock-to-data time
  always @(posedge i_sk) begin
    if (i_cs) begin
      rises = rises + 1;
      if (rises <= 9) cmd = {cmd[7:0], i_di};
      if (rises == 9) begin
        if (reads < 8) begin
          addr_log[reads] = cmd[5:0];
          opc_log[reads] = cmd[8:6];
        end
        reads = reads + 1;
        o_do <= #100 1'b0;
      end else if (rises > 9 && rises < 26) begin
        o_do <= #100 mem[cmd[5:0]][25 - rises];
      end
    end
  end

  // no pull on the line: deselected output shows a changed level
  always @(negedge i_cs) begin
    rises = 0;
    o_do <= ~o_do;
  end
endmodule : rom_model

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("MISMATCH %0t got %h exp %h", $time, got, exp); \
    end \
  end

module tb_top
  import rom_loader_pkg::*;
;
  logic ref_clk, resetn, strap, rom_do, cs, sk, di, wr, rd, bus16, done;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, rdata_w, v, r;
  logic bus16_w;
  logic [8:0] c;
  logic b;
  int errors, checks, r0;

  serial_rom_config_loader i_dut (.i_ref_clk(ref_clk), .i_resetn(resetn),
    .i_rom_present_strap(strap), .i_rom_do(rom_do), .o_rom_cs(cs),
    .o_rom_sk(sk), .o_rom_di(di), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_bus16_sel(bus16), .o_load_done(done));
  rom_model i_rom (.i_cs(cs), .i_sk(sk), .i_di(di), .o_do(rom_do));
  // wide-bus variant runs in lockstep on the same rom data, pins left open
  serial_rom_config_loader #(.BUS32_VARIANT(1'b1)) i_dut_w (
    .i_ref_clk(ref_clk), .i_resetn(resetn), .i_rom_present_strap(strap),
    .i_rom_do(rom_do), .o_rom_cs(), .o_rom_sk(), .o_rom_di(),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata_w), .o_bus16_sel(bus16_w), .o_load_done());

  always #20 ref_clk = ~ref_clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e,
                        input logic [15:0] m = 16'hffff);
    logic [15:0] d;
    rd_reg(a, d);
    `CHK(d & m, e)
  endtask : rd_chk

  // strap only changes while reset is held
  task automatic do_reset(input logic s);
    resetn = 1'b0;
    strap = s;
    cyc(4);
    resetn = 1'b1;
  endtask : do_reset

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 8000) begin
      cyc(1);
      n++;
    end
    if (done !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask : wait_done

  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    strap = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    errors = 0;
    checks = 0;
    foreach (i_rom.mem[i]) i_rom.mem[i] = 16'h0000;
    i_rom.mem[0] = 16'hdead;
    i_rom.mem[1] = 16'h2211;
    i_rom.mem[2] = 16'h4433;
    i_rom.mem[3] = 16'h6655;
    i_rom.mem[4] = 16'hbeef;
    i_rom.mem[5] = 16'h7e7e;
    i_rom.mem[6] = 16'hfffe;
    i_rom.mem[7] = 16'h5a3c;
    do_reset(1'b1);
    // ----------------------------------------------------------------------
    // automatic load, 8-bit width
    // ----------------------------------------------------------------------
    rd_chk(REG_STATION_ADDR_LOW, 16'h0000);
    wr_reg(REG_STATION_ADDR_LOW, 16'h1234);
    wait_done();
    `CHK(i_rom.reads, 7)
    for (int i = 0; i < 7; i++) begin
      `CHK(i_rom.addr_log[i], 6'(i))
      `CHK(i_rom.opc_log[i], 3'h6)
    end
    rd_chk(REG_STATION_ADDR_LOW, 16'h2211);
    rd_chk(REG_STATION_ADDR_MID, 16'h4433);
    rd_chk(REG_STATION_ADDR_HIGH, 16'h6655);
    `CHK(bus16, 1'b0)
    rd_chk(REG_CHIP_CONFIG, 16'h0240);
    wr_reg(REG_CHIP_CONFIG, 16'hffff);
    rd_chk(REG_CHIP_CONFIG, 16'h0240);
    wr_reg(REG_STATION_ADDR_HIGH, 16'ha5c3);
    rd_chk(REG_STATION_ADDR_HIGH, 16'ha5c3);
    wr_reg(8'h30, 16'hffff);
    rd_chk(8'h30, 16'h0000);
    rd_chk(REG_SERIAL_ROM_CONTROL, 16'h0000, 16'hfffe);
    $display("test auto_load done");
    // ----------------------------------------------------------------------
    // software word read of a user word through the control register
    // ----------------------------------------------------------------------
    wr_reg(REG_SERIAL_ROM_CONTROL, 16'hfffe);
    cyc(2);
    `CHK({cs, sk, di}, 3'b111)
    rd_chk(REG_SERIAL_ROM_CONTROL, 16'h001e, 16'hfffe);
    wr_reg(REG_SERIAL_ROM_CONTROL, 16'h0010);
    c = {3'h6, 6'h07};
    v = 16'h0000;
    for (int k = 1; k <= 25; k++) begin
      b = (k <= 9) ? c[9 - k] : 1'b0;
      wr_reg(REG_SERIAL_ROM_CONTROL, {12'h001, b, 3'b010});
      wr_reg(REG_SERIAL_ROM_CONTROL, {12'h001, b, 3'b110});
      cyc(8);
      rd_reg(REG_SERIAL_ROM_CONTROL, r);
      if (k >= 10) v = {v[14:0], r[0]};
    end
    `CHK(v, 16'h5a3c)
    wr_reg(REG_SERIAL_ROM_CONTROL, 16'h0000);
    $display("test software_read done");
    // ----------------------------------------------------------------------
    // second load, 16-bit width
    // ----------------------------------------------------------------------
    i_rom.mem[6] = 16'h8001;
    do_reset(1'b1);
    wait_done();
    `CHK(bus16, 1'b1)
    rd_chk(REG_CHIP_CONFIG, 16'h0280);
    `CHK(rdata_w, 16'h0220)
    `CHK(bus16_w, 1'b0)
    rd_chk(REG_STATION_ADDR_MID, 16'h4433);
    $display("test bus16_load done");
    // ----------------------------------------------------------------------
    // no rom fitted: strap held low
    // ----------------------------------------------------------------------
    r0 = i_rom.reads;
    do_reset(1'b0);
    wr_reg(REG_STATION_ADDR_LOW, 16'h1234);
    wait_done();
    cyc(20);
    `CHK(i_rom.reads, r0)
    rd_chk(REG_STATION_ADDR_LOW, 16'h0000);
    rd_chk(REG_CHIP_CONFIG, 16'h0080);
    $display("test no_rom done");
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
